// ### verilog/cpu_seq_map.vh
`ifndef CPU_SEQ_MAP_VH
`define CPU_SEQ_MAP_VH

// I/O register offsets
`define SP_LOW_IO 6'h3D
`define SP_HIGH_IO 6'h3E
`define STATUS_IO 6'h3F
`define FLAG_IO 6'h3A

// Status register field
`define GIE_BIT 7

// Data space layout
`define REG_FILE_TOP 16'h001F
`define IO_TOP 16'h005F
`define SP_MIN 16'h0060
`define LAST_SRAM 16'h025F
`define SP_BITS 10

// Sequence lengths in core_clk cycles
`define ENTRY_CYCLES 3'h4
`define WAKE_CYCLES 3'h4
`define RETURN_CYCLES 3'h4
`define VECTOR_JUMP_CYCLES 3'h3

// Reset values
`define STATUS_RESET 8'h00

`endif

// ### verilog/alu_regfile.v
`timescale 1ns/10ps
`default_nettype none

// Register file with a two-operand ALU that reads, computes and
// writes back within one clock cycle
module alu_regfile (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Operation request
   input wire alu_go,
   input wire [1:0] alu_op,
   input wire [4:0] alu_rd,
   input wire [4:0] alu_rr,
   // Result as written back
   output reg [7:0] alu_result
);

   // Working registers
   reg [7:0] regs [0:31];
   // Combinational result
   reg [7:0] next_result;
   integer i;

   // Both operands read and combined in the same cycle
   always @* begin
      case (alu_op)
         2'h0: next_result = regs[alu_rd] + regs[alu_rr];
         2'h1: next_result = regs[alu_rd] - regs[alu_rr];
         2'h2: next_result = regs[alu_rd] & regs[alu_rr];
         default: next_result = regs[alu_rd] | regs[alu_rr];
      endcase
   end

   // Write back on the single edge that ends the operation
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < 32; i = i + 1) begin
            regs[i] <= i[7:0]; // Index pattern keeps results observable
         end
         alu_result <= 8'h00;
      end else if (alu_go) begin
         regs[alu_rd] <= next_result;
         alu_result <= next_result;
      end
   end

endmodule

`default_nettype wire

// ### verilog/cpu_stack_interrupt_sequencer.v
// Operation
// - Stack grows downward; pushes lower pointer.
// - Byte push minus one; call/entry minus two.
// - Byte pop plus one; return plus two.
// - Pointer bytes readable/writable at I/O 0x3E/0x3D.
// - Core clock used directly, never divided.
// - Two-register ALU operation completes in one cycle.
// - Take interrupt only with both enables set.
// - Lowest vector wins; reset, then request zero.
// - Entry clears global enable; return sets it.
// - Vectoring or writing one clears flag.
// - Flags held while disabled, served by priority.
// - Level sources request only while present.
// - One main instruction after return before next.
// - Status register never saved or restored automatically.
// - Disable takes effect at once, same cycle.
// - Instruction after enable runs before service.
// - Entry four cycles pushing PC; jump three.
// - Multi-cycle instruction finishes before service.
// - Wake from sleep adds four cycles.
// - Return four cycles: pop PC, plus two, enable.
// - Decode: 32 registers, 64 I/O, then SRAM.
// - Global enable held in status bit seven.
`timescale 1ns/10ps
`default_nettype none
`include "cpu_seq_map.vh"

module cpu_stack_interrupt_sequencer #(
   parameter N_IRQ = 8,
   parameter [7:0] LEVEL_MASK = 8'h00,
   parameter SP_BITS = `SP_BITS,
   parameter [15:0] LAST_SRAM_ADDRESS = `LAST_SRAM
) (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // I/O register port
   input wire [5:0] io_addr,
   input wire io_we,
   input wire io_re,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   // Pipeline events
   input wire instr_done,
   input wire op_push,
   input wire op_pop,
   input wire op_call,
   input wire op_ret,
   input wire op_irq_ret,
   input wire op_sei,
   input wire op_cli,
   input wire sleeping,
   input wire [15:0] pc_in,
   // Stack memory port
   output reg stack_we,
   output reg stack_re,
   output reg [15:0] stack_addr,
   output reg [7:0] stack_wdata,
   input wire [7:0] stack_rdata,
   // Sequencer results
   output reg seq_busy,
   output reg wake_up,
   output reg vector_valid,
   output reg [7:0] vector_number,
   output reg pc_load,
   output reg [15:0] pc_value,
   output reg [15:0] stack_pointer,
   output reg [7:0] status_register,
   // Interrupt sources
   input wire [N_IRQ-1:0] irq_req,
   input wire [N_IRQ-1:0] irq_enable,
   output reg [N_IRQ-1:0] irq_flags,
   // Data space decode
   input wire [15:0] data_addr,
   output reg [2:0] data_region,
   // ALU operation
   input wire alu_go,
   input wire [1:0] alu_op,
   input wire [4:0] alu_rd,
   input wire [4:0] alu_rr,
   output wire [7:0] alu_result
);

   // One-hot sequencer states
   localparam [3:0] ST_RUN = 4'b0001;
   localparam [3:0] ST_WAKE = 4'b0010;
   localparam [3:0] ST_ENTER = 4'b0100;
   localparam [3:0] ST_RETURN = 4'b1000;

   // Implemented pointer bits
   localparam [15:0] SP_MASK = 16'hFFFF >> (16 - SP_BITS);
   // Which sources are level type
   localparam [N_IRQ-1:0] LEVEL = LEVEL_MASK[N_IRQ-1:0];

   // Sequencer state and cycle count within a sequence
   reg [3:0] state;
   reg [2:0] cnt;
   // Blocks service for one instruction after enable or return
   reg shadow;
   // Previous request levels for event detection
   reg [N_IRQ-1:0] req_prev;
   // Captured vector and program counter
   reg [7:0] vec_q;
   reg [N_IRQ-1:0] vec_onehot;
   reg [15:0] pc_q;

   // Pending, qualified and arbitration terms
   wire [N_IRQ-1:0] flag_set;
   wire [N_IRQ-1:0] flag_wclr;
   wire [N_IRQ-1:0] pending;
   wire gie_now;
   wire can_take;
   wire [7:0] winner;
   wire [15:0] sp_plus1;
   wire [15:0] sp_minus1;

   // Lowest set index wins the arbitration
   function [7:0] first_set;
      input [N_IRQ-1:0] v;
      integer k;
      begin
         first_set = 8'h00;
         for (k = N_IRQ - 1; k >= 0; k = k - 1) begin
            if (v[k]) begin
               first_set = k[7:0];
            end
         end
      end
   endfunction

   // One-hot region for a data-space address
   function [2:0] region_of;
      input [15:0] a;
      begin
         if (a <= `REG_FILE_TOP) begin
            region_of = 3'h1;
         end else if (a <= `IO_TOP) begin
            region_of = 3'h2;
         end else begin
            region_of = 3'h4;
         end
      end
   endfunction

   // Keeps the pointer within the implemented bits
   function [15:0] fit_sp;
      input [15:0] v;
      begin
         fit_sp = v & SP_MASK;
      end
   endfunction

   // Flag sources latch on the rising edge of their request
   assign flag_set = irq_req & ~req_prev & ~LEVEL;
   // Writing one to a flag position clears it
   assign flag_wclr = (io_we && io_addr == `FLAG_IO) ?
                      io_wdata[N_IRQ-1:0] : {N_IRQ{1'b0}};
   // Flags held while disabled; level sources only while present
   assign pending = ((irq_flags & ~LEVEL) | (irq_req & LEVEL))
                    & irq_enable;
   // Disable acts in its own cycle
   assign gie_now = status_register[`GIE_BIT] & ~op_cli;
   // Both enables and no one-instruction shadow
   assign can_take = gie_now & (|pending) & ~shadow;
   assign winner = first_set(pending);
   // Stack pointer neighbours
   assign sp_plus1 = fit_sp(stack_pointer + 16'h0001);
   assign sp_minus1 = fit_sp(stack_pointer - 16'h0001);

   // Register file and ALU, clocked straight by core_clk
   alu_regfile u_alu (
      .core_clk(core_clk),
      .rstn(rstn),
      .alu_go(alu_go),
      .alu_op(alu_op),
      .alu_rd(alu_rd),
      .alu_rr(alu_rr),
      .alu_result(alu_result)
   );

   // Interrupt flags: hardware set wins over any clear
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         irq_flags <= {N_IRQ{1'b0}};
         req_prev <= {N_IRQ{1'b0}};
      end else begin
         req_prev <= irq_req;
         if (state == ST_ENTER && cnt == 3'h0) begin
            // Clear the served flag on vectoring
            irq_flags <= ((irq_flags & ~flag_wclr & ~vec_onehot)
                          | flag_set) & ~LEVEL;
         end else begin
            irq_flags <= ((irq_flags & ~flag_wclr) | flag_set)
                         & ~LEVEL;
         end
      end
   end

   // Data-space decode, registered
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_region <= 3'h1;
      end else begin
         data_region <= region_of(data_addr);
      end
   end

   // I/O read port
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         io_rdata <= 8'h00;
      end else if (io_re) begin
         case (io_addr)
            `SP_LOW_IO: io_rdata <= stack_pointer[7:0];
            `SP_HIGH_IO: io_rdata <= stack_pointer[15:8];
            `STATUS_IO: io_rdata <= status_register;
            `FLAG_IO: io_rdata <= {{(8-N_IRQ){1'b0}}, irq_flags};
            // Unmapped offsets read zero
            default: io_rdata <= 8'h00;
         endcase
      end
   end

   // Main sequencer: entry, wake, return and pointer updates
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_RUN;
         cnt <= 3'h0;
         shadow <= 1'b0;
         vec_q <= 8'h00;
         vec_onehot <= {N_IRQ{1'b0}};
         pc_q <= 16'h0000;
         stack_pointer <= fit_sp(LAST_SRAM_ADDRESS);
         status_register <= `STATUS_RESET;
         stack_we <= 1'b0;
         stack_re <= 1'b0;
         stack_addr <= 16'h0000;
         stack_wdata <= 8'h00;
         seq_busy <= 1'b0;
         wake_up <= 1'b0;
         vector_valid <= 1'b0;
         vector_number <= 8'h00;
         pc_load <= 1'b0;
         pc_value <= 16'h0000;
      end else begin
         // Pulses default low
         stack_we <= 1'b0;
         stack_re <= 1'b0;
         wake_up <= 1'b0;
         vector_valid <= 1'b0;
         pc_load <= 1'b0;
         case (state)
            ST_RUN: begin
               // Status register write from software
               if (io_we && io_addr == `STATUS_IO) begin
                  status_register <= io_wdata;
               end
               // Enable and disable instructions
               if (op_sei) begin
                  status_register[`GIE_BIT] <= 1'b1;
               end else if (op_cli) begin
                  status_register[`GIE_BIT] <= 1'b0;
               end
               // Shadow covers the instruction after enable
               if (op_sei) begin
                  shadow <= 1'b1;
               end else if (instr_done) begin
                  shadow <= 1'b0;
               end
               // Pointer written as two bytes
               if (io_we && io_addr == `SP_LOW_IO) begin
                  stack_pointer <= fit_sp({stack_pointer[15:8], io_wdata});
               end else if (io_we && io_addr == `SP_HIGH_IO) begin
                  stack_pointer <= fit_sp({io_wdata, stack_pointer[7:0]});
               end else if (op_push) begin
                  stack_pointer <= sp_minus1;
               end else if (op_call) begin
                  stack_pointer <= fit_sp(stack_pointer - 16'h0002);
               end else if (op_pop) begin
                  stack_pointer <= sp_plus1;
               end else if (op_ret) begin
                  stack_pointer <= fit_sp(stack_pointer + 16'h0002);
               end
               // Choose the next sequence
               if (op_irq_ret) begin
                  state <= ST_RETURN;
                  cnt <= 3'h0;
                  seq_busy <= 1'b1;
               end else if (sleeping && can_take) begin
                  // Core asleep: extra wake-up cycles first
                  state <= ST_WAKE;
                  cnt <= 3'h0;
                  seq_busy <= 1'b1;
                  wake_up <= 1'b1;
                  vec_q <= winner;
                  vec_onehot <= {{(N_IRQ-1){1'b0}}, 1'b1} << winner;
               end else if (instr_done && can_take) begin
                  // Only at an instruction boundary
                  state <= ST_ENTER;
                  cnt <= 3'h0;
                  seq_busy <= 1'b1;
                  vec_q <= winner;
                  vec_onehot <= {{(N_IRQ-1){1'b0}}, 1'b1} << winner;
                  pc_q <= pc_in;
               end
            end
            ST_WAKE: begin
               // Adds four cycles on top of the start-up time
               if (cnt == `WAKE_CYCLES - 3'h1) begin
                  state <= ST_ENTER;
                  cnt <= 3'h0;
                  pc_q <= pc_in;
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end
            ST_ENTER: begin
               // Global enable off; rest of status untouched
               status_register[`GIE_BIT] <= 1'b0;
               if (cnt == 3'h0) begin
                  // Low byte of return address, pointer down
                  stack_we <= 1'b1;
                  stack_addr <= stack_pointer;
                  stack_wdata <= pc_q[7:0];
                  stack_pointer <= sp_minus1;
               end else if (cnt == 3'h1) begin
                  // High byte, pointer down again
                  stack_we <= 1'b1;
                  stack_addr <= stack_pointer;
                  stack_wdata <= pc_q[15:8];
                  stack_pointer <= sp_minus1;
               end
               if (cnt == `ENTRY_CYCLES - 3'h1) begin
                  // Vector executes after four cycles
                  state <= ST_RUN;
                  cnt <= 3'h0;
                  seq_busy <= 1'b0;
                  vector_valid <= 1'b1;
                  vector_number <= vec_q;
                  vec_onehot <= {N_IRQ{1'b0}};
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end
            ST_RETURN: begin
               if (cnt == 3'h0 || cnt == 3'h1) begin
                  // Read one byte above the pointer, pointer up
                  stack_re <= 1'b1;
                  stack_addr <= sp_plus1;
                  stack_pointer <= sp_plus1;
               end
               if (cnt == 3'h1) begin
                  // High byte arrives a cycle after its read
                  pc_q[15:8] <= stack_rdata;
               end else if (cnt == 3'h2) begin
                  pc_q[7:0] <= stack_rdata;
               end
               if (cnt == `RETURN_CYCLES - 3'h1) begin
                  // Reload PC, enable again, shadow one instruction
                  state <= ST_RUN;
                  cnt <= 3'h0;
                  seq_busy <= 1'b0;
                  pc_load <= 1'b1;
                  pc_value <= pc_q;
                  status_register[`GIE_BIT] <= 1'b1;
                  shadow <= 1'b1;
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end
            default: begin
               // Recover from an illegal state code
               state <= ST_RUN;
               cnt <= 3'h0;
               seq_busy <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ### testbench/cpu_stack_interrupt_sequencer_sva.sv
`timescale 1ns/10ps
`default_nettype none

// Port-level checks on the stack and interrupt sequencer
module cpu_seq_checker #(
   parameter N_IRQ = 8,
   parameter SP_BITS = 10
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Pipeline events
   input wire logic instr_done,
   input wire logic op_push,
   input wire logic op_call,
   input wire logic op_irq_ret,
   input wire logic op_cli,
   input wire logic io_we,
   input wire logic sleeping,
   // Stack port
   input wire logic stack_we,
   input wire logic stack_re,
   input wire logic [15:0] stack_addr,
   // Sequencer state
   input wire logic seq_busy,
   input wire logic vector_valid,
   input wire logic [7:0] vector_number,
   input wire logic pc_load,
   input wire logic [15:0] stack_pointer,
   input wire logic [7:0] status_register,
   input wire logic [N_IRQ-1:0] irq_flags,
   // Data space decode
   input wire logic [15:0] data_addr,
   input wire logic [2:0] data_region
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Two return-address bytes written one below the other
   sequence s_push_pc;
      stack_we ##1 stack_we && stack_addr == $past(stack_addr) - 16'h1;
   endsequence
   // Two return-address bytes read back while busy
   sequence s_pop_pc;
      seq_busy && stack_re ##1 stack_re;
   endsequence
   property p_push;
      op_push && !seq_busy && !io_we && !instr_done |=> stack_pointer == $past(stack_pointer) - 16'h1;
   endproperty
   property p_call;
      op_call && !seq_busy && !io_we && !instr_done |=> stack_pointer == $past(stack_pointer) - 16'h2;
   endproperty
   property p_entry;
      $rose(stack_we) |-> s_push_pc ##2 vector_valid && !seq_busy;
   endproperty
   property p_gie_off;
      stack_we |-> !status_register[7];
   endproperty
   property p_ret;
      op_irq_ret && !seq_busy |=> ##1 s_pop_pc ##2 pc_load && status_register[7]
         && stack_pointer == $past(stack_pointer, 4) + 16'h2;
   endproperty
   property p_cli;
      op_cli && instr_done && !sleeping |=> !seq_busy && !status_register[7];
   endproperty
   property p_gate;
      instr_done && !status_register[7] && !seq_busy && !op_irq_ret && !sleeping |=> !seq_busy;
   endproperty
   property p_flag;
      vector_valid |-> !irq_flags[vector_number];
   endproperty
   property p_decode;
      1'b1 |=> data_region == ($past(data_addr) < 16'h0020 ? 3'h1 : $past(data_addr) < 16'h0060 ? 3'h2 : 3'h4);
   endproperty
   property p_sp_bits;
      1'b1 |-> (stack_pointer >> SP_BITS) == 16'h0;
   endproperty
   a_push: assert property (p_push) else $error("push did not lower pointer by one");
   a_call: assert property (p_call) else $error("call did not lower pointer by two");
   a_entry: assert property (p_entry) else $error("entry push or vector timing wrong");
   a_gie_off: assert property (p_gie_off) else $error("global enable set during entry");
   a_ret: assert property (p_ret) else $error("return sequence wrong");
   a_cli: assert property (p_cli) else $error("interrupt taken with disable");
   a_gate: assert property (p_gate) else $error("interrupt taken with global enable off");
   a_flag: assert property (p_flag) else $error("served flag still set");
   a_decode: assert property (p_decode) else $error("data region wrong");
   a_sp_bits: assert property (p_sp_bits) else $error("unimplemented pointer bits set");
endmodule

bind cpu_stack_interrupt_sequencer cpu_seq_checker #(.N_IRQ(N_IRQ), .SP_BITS(SP_BITS)) chk_u (
   .core_clk(core_clk), .rstn(rstn), .instr_done(instr_done), .op_push(op_push), .op_call(op_call),
   .op_irq_ret(op_irq_ret), .op_cli(op_cli), .io_we(io_we), .sleeping(sleeping), .stack_we(stack_we),
   .stack_re(stack_re), .stack_addr(stack_addr), .seq_busy(seq_busy), .vector_valid(vector_valid),
   .vector_number(vector_number), .pc_load(pc_load), .stack_pointer(stack_pointer),
   .status_register(status_register), .irq_flags(irq_flags), .data_addr(data_addr), .data_region(data_region));

`default_nettype wire

// ### testbench/stack_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural stack SRAM on the sequencer's stack port
module stack_mem_model (
   // Clock
   input wire logic core_clk,
   // Stack port
   input wire logic stack_we,
   input wire logic stack_re,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   output logic [7:0] stack_rdata
);
   logic [7:0] mem [0:1023]; // Store for the implemented range
   logic [7:0] junk = 8'hA5; // Pattern shown when not read
   // Store pushed bytes; keep the idle pattern moving
   always @(posedge core_clk) begin
      if (stack_we) begin
         mem[stack_addr[9:0]] <= stack_wdata;
      end
      junk <= ~junk;
   end
   // Data only in the cycle of the read strobe
   assign stack_rdata = stack_re ? mem[stack_addr[9:0]] : junk;
endmodule

`default_nettype wire

// ### testbench/tb_cpu_stack_interrupt_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_cpu_stack_interrupt_sequencer;
   // Stimulus
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [5:0] io_addr = 6'h00;
   logic io_we = 1'b0;
   logic io_re = 1'b0;
   logic [7:0] io_wdata = 8'h00;
   logic [7:0] ops = 8'h00; // cli sei irq_ret ret call pop push done
   logic sleeping = 1'b0;
   logic [15:0] pc_in = 16'h1234;
   logic [7:0] irq_req = 8'h00;
   logic [7:0] irq_enable = 8'h00;
   logic [15:0] data_addr = 16'h0000;
   logic alu_go = 1'b0;
   logic [1:0] alu_op = 2'h1;
   logic [4:0] alu_rd = 5'h05;
   logic [4:0] alu_rr = 5'h03;
   // Design outputs
   wire [7:0] io_rdata, stack_wdata, stack_rdata, vector_number, status_register, irq_flags, alu_result;
   wire [15:0] stack_addr, pc_value, stack_pointer;
   wire [2:0] data_region;
   wire stack_we, stack_re, seq_busy, wake_up, vector_valid, pc_load;
   // Bench state
   int n_mismatch = 0;
   int compares = 0;
   int n;
   logic [7:0] d;
   localparam logic [7:0] DONE = 8'h01, PUSH = 8'h02, POP = 8'h04, CALL = 8'h08;
   localparam logic [7:0] RET = 8'h10, IRQ_RET = 8'h20, SEI = 8'h40, CLI = 8'h80;

   cpu_stack_interrupt_sequencer #(.LEVEL_MASK(8'h80)) dut_u (
      .core_clk(core_clk), .rstn(rstn), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .instr_done(ops[0]), .op_push(ops[1]), .op_pop(ops[2]),
      .op_call(ops[3]), .op_ret(ops[4]), .op_irq_ret(ops[5]), .op_sei(ops[6]), .op_cli(ops[7]),
      .sleeping(sleeping), .pc_in(pc_in), .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .stack_rdata(stack_rdata), .seq_busy(seq_busy), .wake_up(wake_up),
      .vector_valid(vector_valid), .vector_number(vector_number), .pc_load(pc_load), .pc_value(pc_value),
      .stack_pointer(stack_pointer), .status_register(status_register), .irq_req(irq_req),
      .irq_enable(irq_enable), .irq_flags(irq_flags), .data_addr(data_addr), .data_region(data_region),
      .alu_go(alu_go), .alu_op(alu_op), .alu_rd(alu_rd), .alu_rr(alu_rr), .alu_result(alu_result));

   stack_mem_model mem_u (.core_clk(core_clk), .stack_we(stack_we), .stack_re(stack_re),
      .stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata));

   // Undivided core clock, 25 ns period
   always #12.5 core_clk = ~core_clk;

   // Counts and verdict
   task complete_run;
      $display("Compares %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One cycle of pipeline events
   task step(input logic [7:0] m);
      ops = m;
      @(negedge core_clk);
   endtask
   // Bounded wait for vector (0), pc load (1) or wake (2)
   task wait_for(input int which, output int k);
      ops = 8'h00;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while ((which == 0 ? vector_valid : which == 1 ? pc_load : wake_up) !== 1'b1 && k < 40);
      if ((which == 0 ? vector_valid : which == 1 ? pc_load : wake_up) !== 1'b1) begin
         n_mismatch++;
         complete_run;
      end
   endtask
   // I/O register cycles
   task io_write(input logic [5:0] a, input logic [7:0] v);
      io_addr = a;
      io_wdata = v;
      io_we = 1'b1;
      @(negedge core_clk);
      io_we = 1'b0;
      @(negedge core_clk);
   endtask
   task io_read(input logic [5:0] a, output logic [7:0] v);
      io_addr = a;
      io_re = 1'b1;
      @(negedge core_clk);
      io_re = 1'b0;
      v = io_rdata;
      @(negedge core_clk);
   endtask
   // Register map and pointer bytes
   task t_regs;
      `CHECK("sp reset", 16'h025F, stack_pointer)
      `CHECK("status reset", 8'h00, status_register)
      io_write(6'h3D, 8'h80);
      io_write(6'h3E, 8'hFF);
      io_read(6'h3E, d);
      `CHECK("sp high", 8'h03, d)
      io_write(6'h3E, 8'h02);
      io_read(6'h3D, d);
      `CHECK("sp low", 8'h80, d)
      `CHECK("sp", 16'h0280, stack_pointer)
      io_read(6'h10, d);
      `CHECK("unmapped", 8'h00, d)
   endtask
   // Back-to-back stack operations
   task t_stack;
      step(PUSH);
      `CHECK("push", 16'h027F, stack_pointer)
      step(CALL);
      `CHECK("call", 16'h027D, stack_pointer)
      step(POP);
      `CHECK("pop", 16'h027E, stack_pointer)
      step(RET);
      `CHECK("ret", 16'h0280, stack_pointer)
      step(8'h00);
   endtask
   // Entry, priority, return and the one-instruction gap
   task t_entry;
      io_write(6'h3F, 8'h15);
      irq_enable = 8'h05;
      irq_req = 8'h05;
      step(DONE);
      step(8'h00);
      `CHECK("held flags", 8'h05, irq_flags)
      `CHECK("no take gie off", 1'b0, seq_busy)
      step(SEI | DONE);
      step(DONE);
      `CHECK("after sei", 1'b0, seq_busy)
      step(8'h00);
      `CHECK("mid instruction", 1'b0, seq_busy)
      step(DONE);
      wait_for(0, n);
      `CHECK("entry cycles", 4, n)
      `CHECK("winner", 8'h00, vector_number)
      `CHECK("flag cleared", 8'h04, irq_flags)
      `CHECK("status kept", 8'h15, status_register)
      `CHECK("sp entry", 16'h027E, stack_pointer)
      `CHECK("pc low", 8'h34, mem_u.mem[10'h280])
      `CHECK("pc high", 8'h12, mem_u.mem[10'h27F])
      irq_req = 8'h00;
      step(IRQ_RET);
      wait_for(1, n);
      `CHECK("ret cycles", 4, n)
      `CHECK("pc back", 16'h1234, pc_value)
      `CHECK("sp ret", 16'h0280, stack_pointer)
      `CHECK("status ret", 8'h95, status_register)
      io_read(6'h3F, d);
      `CHECK("status read", 8'h95, d)
      step(DONE);
      `CHECK("gap after return", 1'b0, seq_busy)
      step(DONE);
      wait_for(0, n);
      `CHECK("second", 8'h02, vector_number)
      step(IRQ_RET);
      wait_for(1, n);
   endtask
   // Level source, then disable racing a pending flag
   task t_level_cli;
      step(DONE);
      irq_req = 8'h80;
      step(DONE);
      irq_req = 8'h00;
      step(8'h00);
      irq_enable = 8'h85;
      step(DONE);
      `CHECK("level gone", 1'b0, seq_busy)
      irq_req = 8'h80;
      step(DONE);
      wait_for(0, n);
      `CHECK("level served", 8'h07, vector_number)
      irq_req = 8'h00;
      step(IRQ_RET);
      wait_for(1, n);
      step(DONE);
      irq_req = 8'h04;
      step(8'h00);
      step(CLI | DONE);
      step(8'h00);
      `CHECK("cli blocks", 1'b0, seq_busy)
      `CHECK("cli gie", 1'b0, status_register[7])
      io_write(6'h3A, 8'h04);
      `CHECK("flag write one", 8'h00, irq_flags)
      irq_req = 8'h00;
   endtask
   // Wake from sleep adds four cycles
   task t_sleep;
      step(SEI | DONE);
      step(DONE);
      sleeping = 1'b1;
      irq_req = 8'h04;
      wait_for(2, n);
      wait_for(0, n);
      `CHECK("wake cycles", 8, n)
      sleeping = 1'b0;
      irq_req = 8'h00;
      step(IRQ_RET);
      wait_for(1, n);
   endtask
   // Region boundaries and single-cycle ALU
   task t_decode_alu;
      logic [15:0] a [5] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060};
      logic [2:0] r [5] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4};
      for (int i = 0; i < 5; i++) begin
         data_addr = a[i];
         @(negedge core_clk);
         `CHECK("region", r[i], data_region)
      end
      alu_go = 1'b1;
      @(negedge core_clk);
      alu_go = 1'b0;
      `CHECK("alu sub", 8'h02, alu_result)
      alu_op = 2'h0;
      alu_rr = 5'h05;
      @(negedge core_clk);
      alu_go = 1'b1;
      @(negedge core_clk);
      alu_go = 1'b0;
      `CHECK("alu write back", 8'h04, alu_result)
   endtask

   // Reset, then the scenarios in order
   initial begin
      repeat (10) @(negedge core_clk);
      rstn = 1'b1;
      @(negedge core_clk);
      t_regs;
      t_stack;
      t_entry;
      t_level_cli;
      t_sleep;
      t_decode_alu;
      complete_run;
   end
endmodule

`default_nettype wire
